// File: shared/gsp_map.svh
// constants for the misc pin logic: pin indices, reset values, strobe timing
`ifndef GSP_MAP_SVH
`define GSP_MAP_SVH

`define GSP_NUM_PINS 6
`define GSP_PIN_SCL 0
`define GSP_PIN_SDA 1
`define GSP_PIN_IRQ_LO 2
`define GSP_PIN_IRQ_HI 3
`define GSP_PIN_WR 4
`define GSP_PIN_RD 5
`define GSP_BUS_DW 16
`define GSP_CLK_PERIOD_NS 10
`define GSP_STROBE_NS 30
`define GSP_STROBE_CYC ((`GSP_STROBE_NS + `GSP_CLK_PERIOD_NS - 1) / `GSP_CLK_PERIOD_NS)
`define GSP_RST_PIN_OE_N 1'b1
`define GSP_RST_PIN_VAL 1'b0
`define GSP_RST_PIN_IN 1'b1
`define GSP_RST_STROBE_N 1'b1

`endif

// File: shared/gsp_pkg.sv
// types for the misc pin logic
package gsp_pkg;
  typedef enum logic [1:0] {
    GSP_ST_IDLE = 2'b00,
    GSP_ST_WR = 2'b01,
    GSP_ST_RD = 2'b10
  } gsp_bus_st_t;
  typedef logic [3:0] gsp_cnt_t;
endpackage : gsp_pkg

// File: src/gsp_pin_cell.sv
// one general-purpose pin: registered driver and registered input sample
`timescale 1ns/1ps
`include "gsp_map.svh"
module gsp_pin_cell
  import gsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic drive_i,
  input wire logic val_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_n_o,
  output logic in_o,
  output logic rise_o
);
  logic pad_r, pad_nxt;
  logic oe_n_r, oe_n_nxt;
  logic in_r, in_nxt;
  logic rise_r, rise_nxt;

  always_comb begin
    pad_nxt = val_i;
    oe_n_nxt = ~drive_i;
    in_nxt = pad_i;
    rise_nxt = pad_i & ~in_r;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_r <= `GSP_RST_PIN_VAL;
      oe_n_r <= `GSP_RST_PIN_OE_N;
      in_r <= `GSP_RST_PIN_IN; // pulled-up idle level, no false edge after reset
      rise_r <= 1'b0;
    end else begin
      pad_r <= pad_nxt;
      oe_n_r <= oe_n_nxt;
      in_r <= in_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign pad_o = pad_r;
  assign pad_oe_n_o = oe_n_r;
  assign in_o = in_r;
  assign rise_o = rise_r;
endmodule : gsp_pin_cell

// File: src/gsp_misc_pins.sv
// global reset, wake-up event output and six general-purpose pins
//
// Function
// - The global power-on reset returns every internal register to its reset value.
// - Wake-up events are signalled on an open-drain PME output that only ever pulls low.
// - Each general-purpose pin is a software-programmed input or output unless an alternate function owns it.
// - Pins 3 and 2, as inputs, can be enabled to raise generic interrupt events.
// - Pin 0 is sampled as global reset ends and latched as the serial ROM present strap.
// - With the strap high, pin 0 carries the ROM clock and pin 1 the ROM data line.
// - Pin 4 is an active-low write strobe whose rising edge marks bus data valid.
// - Pin 5 is an active-low read strobe whose rising edge marks bus data valid.
// - The bus reset puts all logic except the wake-up event logic, the serial ROM strap and the strap-owned pins 0 and 1 into a defined state.
`timescale 1ns/1ps
`include "gsp_map.svh"
module gsp_misc_pins
  import gsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pci_rst_n_i,
  input wire logic pme_event_i,
  input wire logic pme_clear_i,
  input wire logic [`GSP_NUM_PINS-1:0] gp_dir_i,
  input wire logic [`GSP_NUM_PINS-1:0] gp_out_i,
  input wire logic [1:0] gp_irq_en_i,
  input wire logic gp_bus_en_i,
  input wire logic bus_wr_req_i,
  input wire logic bus_rd_req_i,
  input wire logic [`GSP_BUS_DW-1:0] bus_rd_data_i,
  input wire logic sroom_scl_i,
  input wire logic sroom_sda_low_i,
  input wire logic [`GSP_NUM_PINS-1:0] gp_pin_i,
  output logic [`GSP_NUM_PINS-1:0] gp_pin_o,
  output logic [`GSP_NUM_PINS-1:0] gp_pin_oe_n_o,
  output logic [`GSP_NUM_PINS-1:0] gp_in_o,
  output logic [1:0] gp_irq_o,
  output logic pme_o,
  output logic pme_oe_n_o,
  output logic sroom_present_o,
  output logic sroom_sda_o,
  output logic bus_busy_o,
  output logic bus_wr_done_o,
  output logic bus_rd_done_o,
  output logic [`GSP_BUS_DW-1:0] bus_rd_data_o
);
  // wake-up event latch, untouched by the bus reset
  logic pme_act_r, pme_act_nxt;

  always_comb begin
    pme_act_nxt = pme_act_r;
    if (pme_clear_i) begin
      pme_act_nxt = 1'b0;
    end
    if (pme_event_i) begin
      pme_act_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pme_act_r <= 1'b0;
    end else begin
      pme_act_r <= pme_act_nxt;
    end
  end

  // open drain: value always low, enable low only while pulling
  assign pme_o = 1'b0;
  assign pme_oe_n_o = ~pme_act_r;

  // serial ROM strap, caught on the first edge after global reset release
  logic strap_taken_r, strap_taken_nxt;
  logic strap_r, strap_nxt;

  always_comb begin
    strap_taken_nxt = 1'b1;
    strap_nxt = strap_r;
    if (!strap_taken_r) begin
      strap_nxt = gp_pin_i[`GSP_PIN_SCL];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_taken_r <= 1'b0;
      strap_r <= 1'b0;
    end else begin
      strap_taken_r <= strap_taken_nxt;
      strap_r <= strap_nxt;
    end
  end

  assign sroom_present_o = strap_r;

  // general-purpose bus strobe sequencer
  gsp_bus_st_t st_r, st_nxt;
  gsp_cnt_t cnt_r, cnt_nxt;
  logic wr_n_r, wr_n_nxt;
  logic rd_n_r, rd_n_nxt;
  logic wr_done_r, wr_done_nxt;
  logic rd_done_r, rd_done_nxt;
  logic [`GSP_BUS_DW-1:0] rdata_r, rdata_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_n_nxt = wr_n_r;
    rd_n_nxt = rd_n_r;
    wr_done_nxt = 1'b0;
    rd_done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (st_r)
      GSP_ST_IDLE: begin
        if (gp_bus_en_i && bus_wr_req_i) begin
          st_nxt = GSP_ST_WR;
          wr_n_nxt = 1'b0;
          cnt_nxt = gsp_cnt_t'(`GSP_STROBE_CYC - 1);
        end else if (gp_bus_en_i && bus_rd_req_i) begin
          st_nxt = GSP_ST_RD;
          rd_n_nxt = 1'b0;
          cnt_nxt = gsp_cnt_t'(`GSP_STROBE_CYC - 1);
        end
      end
      GSP_ST_WR: begin
        if (cnt_r == 4'h0) begin
          st_nxt = GSP_ST_IDLE;
          wr_n_nxt = 1'b1;
          wr_done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      GSP_ST_RD: begin
        if (cnt_r == 4'h0) begin
          st_nxt = GSP_ST_IDLE;
          rd_n_nxt = 1'b1;
          rd_done_nxt = 1'b1;
          rdata_nxt = bus_rd_data_i;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        st_nxt = GSP_ST_IDLE;
        wr_n_nxt = 1'b1;
        rd_n_nxt = 1'b1;
      end
    endcase
    if (!pci_rst_n_i) begin
      st_nxt = GSP_ST_IDLE;
      cnt_nxt = 4'h0;
      wr_n_nxt = `GSP_RST_STROBE_N;
      rd_n_nxt = `GSP_RST_STROBE_N;
      wr_done_nxt = 1'b0;
      rd_done_nxt = 1'b0;
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= GSP_ST_IDLE;
      cnt_r <= 4'h0;
      wr_n_r <= `GSP_RST_STROBE_N;
      rd_n_r <= `GSP_RST_STROBE_N;
      wr_done_r <= 1'b0;
      rd_done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_n_r <= wr_n_nxt;
      rd_n_r <= rd_n_nxt;
      wr_done_r <= wr_done_nxt;
      rd_done_r <= rd_done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  logic busy_r, busy_nxt;

  always_comb begin
    busy_nxt = (st_nxt != GSP_ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  assign bus_busy_o = busy_r;
  assign bus_wr_done_o = wr_done_r;
  assign bus_rd_done_o = rd_done_r;
  assign bus_rd_data_o = rdata_r;

  // per-pin owner select and driver cells
  logic [`GSP_NUM_PINS-1:0] drv;
  logic [`GSP_NUM_PINS-1:0] val;
  logic [`GSP_NUM_PINS-1:0] rise;

  genvar gi;
  generate
    for (gi = 0; gi < `GSP_NUM_PINS; gi++) begin : g_pin
      always_comb begin
        drv[gi] = gp_dir_i[gi] & pci_rst_n_i;
        val[gi] = gp_out_i[gi];
        if ((gi == `GSP_PIN_SCL || gi == `GSP_PIN_SDA) && !strap_taken_r) begin
          drv[gi] = 1'b0; // rom lines stay released while the strap is caught
        end else if (gi == `GSP_PIN_SCL && strap_r) begin
          drv[gi] = 1'b1;
          val[gi] = sroom_scl_i;
        end else if (gi == `GSP_PIN_SDA && strap_r) begin
          drv[gi] = sroom_sda_low_i;
          val[gi] = 1'b0;
        end else if (gi == `GSP_PIN_WR && gp_bus_en_i) begin
          drv[gi] = pci_rst_n_i;
          val[gi] = wr_n_r;
        end else if (gi == `GSP_PIN_RD && gp_bus_en_i) begin
          drv[gi] = pci_rst_n_i;
          val[gi] = rd_n_r;
        end
      end

      gsp_pin_cell u_cell (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .drive_i(drv[gi]),
        .val_i(val[gi]),
        .pad_i(gp_pin_i[gi]),
        .pad_o(gp_pin_o[gi]),
        .pad_oe_n_o(gp_pin_oe_n_o[gi]),
        .in_o(gp_in_o[gi]),
        .rise_o(rise[gi])
      );
    end
  endgenerate

  assign sroom_sda_o = gp_in_o[`GSP_PIN_SDA];

  // generic interrupt events from pins 3 and 2 when they are inputs
  logic [1:0] irq_r, irq_nxt;

  always_comb begin
    irq_nxt[0] = gp_irq_en_i[0] & ~gp_dir_i[`GSP_PIN_IRQ_LO] & rise[`GSP_PIN_IRQ_LO];
    irq_nxt[1] = gp_irq_en_i[1] & ~gp_dir_i[`GSP_PIN_IRQ_HI] & rise[`GSP_PIN_IRQ_HI];
    if (!pci_rst_n_i) begin
      irq_nxt = 2'h0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 2'h0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign gp_irq_o = irq_r;
endmodule : gsp_misc_pins

// File: dv/gsp_ext_model.sv
// far-side pads: peripheral drivers, pull-ups and loopback
`timescale 1ns/1ps
module gsp_ext_model (
  input wire logic [5:0] pad_o_i,
  input wire logic [5:0] oe_n_i,
  input wire logic [5:0] drv_i,
  input wire logic [5:0] drv_en_i,
  output logic [5:0] pad_i_o
);
  // device wins, then peripheral, else pull-up
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      pad_i_o[k] = !oe_n_i[k] ? pad_o_i[k] : (drv_en_i[k] ? drv_i[k] : 1'b1);
    end
  end
endmodule : gsp_ext_model

// File: dv/gsp_misc_pins_sva.sv
// assertions on the misc pin logic ports
`timescale 1ns/1ps
module gsp_misc_pins_sva (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pci_rst_n_i,
  input wire logic pme_event_i,
  input wire logic pme_clear_i,
  input wire logic sroom_scl_i,
  input wire logic [5:0] gp_pin_o,
  input wire logic [5:0] gp_pin_oe_n_o,
  input wire logic [5:0] gp_in_o,
  input wire logic [1:0] gp_irq_o,
  input wire logic pme_oe_n_o,
  input wire logic sroom_present_o,
  input wire logic bus_busy_o,
  input wire logic bus_wr_done_o,
  input wire logic bus_rd_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_strobe_end(b);
    !b ##1 b;
  endsequence
  a_pme_set: assert property (pme_event_i |=> !pme_oe_n_o) else $error("pme not raised");
  a_pme_hold: assert property (!pme_oe_n_o && !pme_clear_i |=> !pme_oe_n_o) else $error("pme lost");
  a_wr_strobe: assert property (bus_wr_done_o |-> s_strobe_end(gp_pin_o[4])) else $error("write strobe");
  a_rd_strobe: assert property (bus_rd_done_o |-> s_strobe_end(gp_pin_o[5])) else $error("read strobe");
  a_busy_bound: assert property (bus_busy_o |-> ##[1:3] !bus_busy_o) else $error("busy too long");
  a_irq_cause: assert property (gp_irq_o[1] |-> $past(gp_in_o[3]) && !$past(gp_in_o[3], 2))
    else $error("irq without edge");
  a_strap_route: assert property (sroom_present_o && $past(sroom_present_o, 2) |->
    !gp_pin_oe_n_o[0] && gp_pin_o[0] == $past(sroom_scl_i)) else $error("rom clock");
  a_rst_release: assert property (!pci_rst_n_i |=> gp_pin_oe_n_o[5:2] == 4'hF) else $error("pins held");
endmodule : gsp_misc_pins_sva
bind gsp_misc_pins gsp_misc_pins_sva u_sva (.clk_i, .arst_n_i, .pci_rst_n_i, .pme_event_i, .pme_clear_i,
  .sroom_scl_i, .gp_pin_o, .gp_pin_oe_n_o, .gp_in_o, .gp_irq_o, .pme_oe_n_o, .sroom_present_o, .bus_busy_o,
  .bus_wr_done_o, .bus_rd_done_o);

// File: dv/tb.sv
// testbench for the misc pin logic
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, arst_n_i = 0, pci_rst_n_i = 0, pme_event_i = 0, pme_clear_i = 0, gp_bus_en_i = 0;
  logic bus_wr_req_i = 0, bus_rd_req_i = 0, sroom_scl_i = 0, sroom_sda_low_i = 0;
  logic [5:0] gp_dir_i = 6'h00, gp_out_i = 6'h00, drv = 6'h00, drv_en = 6'h01;
  logic [1:0] gp_irq_en_i = 2'h0;
  logic [15:0] bus_rd_data_i = 16'h0000;
  logic [5:0] gp_pin_i, gp_pin_o, gp_pin_oe_n_o, gp_in_o;
  logic [1:0] gp_irq_o;
  logic pme_o, pme_oe_n_o, sroom_present_o, sroom_sda_o, bus_busy_o, bus_wr_done_o, bus_rd_done_o;
  logic [15:0] bus_rd_data_o;
  int n_mismatch = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  gsp_misc_pins DUT (.clk_i, .arst_n_i, .pci_rst_n_i, .pme_event_i, .pme_clear_i, .gp_dir_i, .gp_out_i,
    .gp_irq_en_i, .gp_bus_en_i, .bus_wr_req_i, .bus_rd_req_i, .bus_rd_data_i, .sroom_scl_i, .sroom_sda_low_i,
    .gp_pin_i, .gp_pin_o, .gp_pin_oe_n_o, .gp_in_o, .gp_irq_o, .pme_o, .pme_oe_n_o, .sroom_present_o,
    .sroom_sda_o, .bus_busy_o, .bus_wr_done_o, .bus_rd_done_o, .bus_rd_data_o);
  gsp_ext_model u_ext (.pad_o_i(gp_pin_o), .oe_n_i(gp_pin_oe_n_o), .drv_i(drv), .drv_en_i(drv_en),
    .pad_i_o(gp_pin_i));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic t_gpio;
    @(posedge clk_i);
    gp_dir_i <= 6'h3C;
    gp_out_i <= 6'h14;
    cyc(3);
    #1;
    chk("pin_val", 4'h5, gp_pin_o[5:2]);
    chk("pin_oe_n", 6'h03, gp_pin_oe_n_o);
    chk("pin_in", 6'h16, gp_in_o);
  endtask : t_gpio
  task automatic t_irq;
    logic [1:0] seen;
    seen = 2'h0;
    @(posedge clk_i);
    gp_dir_i <= 6'h04;
    gp_out_i <= 6'h00;
    gp_irq_en_i <= 2'h3;
    drv_en <= 6'h0D;
    cyc(3);
    drv <= 6'h0C;
    gp_out_i <= 6'h04;
    repeat (4) begin
      @(posedge clk_i);
      #1;
      seen |= gp_irq_o;
    end
    chk("irq", 2'h2, seen);
    @(posedge clk_i);
    gp_irq_en_i <= 2'h0;
  endtask : t_irq
  task automatic t_bus;
    @(posedge clk_i);
    gp_bus_en_i <= 1'b1;
    bus_rd_data_i <= 16'hA5C3;
    bus_wr_req_i <= 1'b1;
    cyc(1);
    bus_wr_req_i <= 1'b0;
    cyc(1);
    #1;
    chk("wr_low", 2'h0, {gp_pin_o[4], gp_pin_oe_n_o[4]});
    cyc(2);
    bus_rd_req_i <= 1'b1;
    #1;
    chk("wr_done", 2'h2, {bus_wr_done_o, bus_busy_o});
    cyc(1);
    bus_rd_req_i <= 1'b0;
    cyc(2);
    #1;
    chk("rd_low", 1'b0, gp_pin_o[5]);
    cyc(1);
    #1;
    chk("rd_done", 1'b1, bus_rd_done_o);
    chk("rd_data", 16'hA5C3, bus_rd_data_o);
  endtask : t_bus
  task automatic t_pme;
    @(posedge clk_i);
    pme_event_i <= 1'b1;
    cyc(1);
    pme_event_i <= 1'b0;
    pci_rst_n_i <= 1'b0;
    cyc(2);
    pci_rst_n_i <= 1'b1;
    #1;
    chk("pme_kept", 1'b0, pme_oe_n_o);
    chk("pme_val", 1'b0, pme_o);
    chk("rst_oe_n", 6'h3F, gp_pin_oe_n_o);
    chk("rst_rdata", 16'h0000, bus_rd_data_o);
    @(posedge clk_i);
    pme_clear_i <= 1'b1;
    pme_event_i <= 1'b1;
    cyc(1);
    pme_event_i <= 1'b0;
    #1;
    chk("pme_set_wins", 1'b0, pme_oe_n_o);
    cyc(1);
    pme_clear_i <= 1'b0;
    #1;
    chk("pme_clr", 1'b1, pme_oe_n_o);
  endtask : t_pme
  task automatic t_strap;
    @(posedge clk_i);
    drv_en <= 6'h00;
    arst_n_i <= 1'b0;
    cyc(2);
    arst_n_i <= 1'b1;
    gp_dir_i <= 6'h03;
    gp_out_i <= 6'h02;
    sroom_scl_i <= 1'b1;
    sroom_sda_low_i <= 1'b1;
    cyc(5);
    #1;
    chk("strap", 1'b1, sroom_present_o);
    chk("rom_pins", 4'h4, {gp_pin_o[1:0], gp_pin_oe_n_o[1:0]});
    chk("rom_sda", 1'b0, sroom_sda_o);
  endtask : t_strap
  initial begin
    cyc(12);
    #1;
    chk("rst_oe_n", 6'h3F, gp_pin_oe_n_o);
    chk("rst_misc", 5'h10, {pme_oe_n_o, gp_irq_o, bus_busy_o, sroom_present_o});
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    pci_rst_n_i <= 1'b1;
    cyc(3);
    t_gpio();
    t_irq();
    t_bus();
    t_pme();
    t_strap();
    results();
  end
  initial begin
    #2000;
    n_mismatch++;
    results();
  end
endmodule : tb
